/* sbm_pkg.sv */
// How it works
// - synth step is crystal over two^19
// - carrier word is 24 bits, three bytes
// - low byte write commits new carrier
// - bit rate is crystal over 16-bit divider
// - plain continuous mode passes data straight
// - shaped mode gives bit clock, host follows
// - deviation is a 14-bit word
// - host keeps deviation plus half rate bounded
// - host keeps deviation above the minimum
// - test bit selects external clock source
// - crystal divided by 2 to 128 on pin
// - clock out on except sleep, default on
// - clock out only after crystal stable
// - sequencer starts pll once crystal stable
// - sequencer enables rx or tx on lock
// - lock indicator high inside locking range
// - coarse cal at reset, fine per activation
// - fsk alters divider, ook switches amplifier
package sbm_pkg;
  // device register index, sent on the link unchanged
  localparam logic [6:0] REG_MODE = 7'h01;
  localparam logic [6:0] REG_RATE_HI = 7'h03;
  localparam logic [6:0] REG_RATE_LO = 7'h04;
  localparam logic [6:0] REG_DEV_HI = 7'h05;
  localparam logic [6:0] REG_DEV_LO = 7'h06;
  localparam logic [6:0] REG_FREQ_HI = 7'h07;
  localparam logic [6:0] REG_FREQ_MID = 7'h08;
  localparam logic [6:0] REG_FREQ_LO = 7'h09;
  localparam logic [6:0] REG_PIN_MAP2 = 7'h26;
  localparam logic [6:0] REG_STATUS = 7'h27;
  localparam logic [6:0] REG_TEST_OSC = 7'h59;
  // mode register fields
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_SEQ_OFF_BIT = 3;
  localparam int MODE_SHAPE_BIT = 4;
  localparam int MODE_OOK_BIT = 5;
  localparam logic [2:0] OP_SLEEP = 3'h0;
  localparam logic [2:0] OP_STBY = 3'h1;
  localparam logic [2:0] OP_FS = 3'h2;
  localparam logic [2:0] OP_TX = 3'h3;
  localparam logic [2:0] OP_RX = 3'h4;
  localparam int EXT_CLK_BIT = 4;
  localparam logic [2:0] REFERENCE_CLOCK_OUT_OFF = 3'h7;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] PIN_MAP2_RST = 8'h00;
  localparam logic [15:0] RATE_RST = 16'h1a0b;
  localparam logic [13:0] DEV_RST = 14'h0052;
  localparam logic [23:0] FREQ_RST = 24'he4c000;
  localparam int FRAC_BITS = 19;
  // status bits
  localparam int ST_OSC_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_RXEN_BIT = 2;
  localparam int ST_TXEN_BIT = 3;
  localparam int ST_CAL_BIT = 4;
  // controller apb offsets
  localparam logic [11:0] CTL_ADDR = 12'h000;
  localparam logic [11:0] CTL_WDATA = 12'h004;
  localparam logic [11:0] CTL_CMD = 12'h008;
  localparam logic [11:0] CTL_STAT = 12'h00c;
  localparam logic [11:0] CTL_TXBITS = 12'h010;
  // timing in cycles of pclk (crystal domain)
  localparam int OSC_STARTUP_CYC = 64;
  localparam int LOCK_CYC = 32;
  localparam int COARSE_CAL_CYC = 16;
  localparam int FINE_CAL_CYC = 8;
  typedef enum logic [4:0] {
    SBM_OFF = 5'b00001,
    SBM_CAL = 5'b00010,
    SBM_LOCKING = 5'b00100,
    SBM_LOCKED = 5'b01000,
    SBM_ACTIVE = 5'b10000
  } sbm_seq_t;
endpackage

/* sbm_link_if.sv */
`timescale 1ns/10ps
interface sbm_link_if;
  logic reg_we;
  logic reg_re;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic tx_data;
  logic tx_bit_clock;
  logic reference_clock_out;
  logic lock_ind;
  logic ext_clk_req;
  modport dev (input reg_we, reg_re, reg_addr, reg_wdata, tx_data,
    output reg_rdata, reg_rvalid, tx_bit_clock, reference_clock_out, lock_ind,
    ext_clk_req);
  modport host (output reg_we, reg_re, reg_addr, reg_wdata, tx_data,
    input reg_rdata, reg_rvalid, tx_bit_clock, reference_clock_out, lock_ind,
    ext_clk_req);
endinterface

/* sbm_device.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module sbm_device #(
  parameter int OSC_CYC = sbm_pkg::OSC_STARTUP_CYC,
  parameter int LOCK_WAIT = sbm_pkg::LOCK_CYC
) (
  input wire logic pclk, // crystal clock
  input wire logic presetn, // async reset
  sbm_link_if.dev lnk, // register and data link
  input wire logic pll_in_range, // analog lock-range status
  output logic [23:0] synth_word, // active carrier word
  output logic [13:0] dev_word, // deviation word
  output logic mod_bit, // data bit to modulator
  output logic pa_on, // amplifier enable
  output logic rx_en, // receiver enable
  output logic cal_busy // vco calibration running
);
  initial
  begin
    if (OSC_CYC < 1 || LOCK_WAIT < 1)
    begin
      $error("sbm_device: counts must be at least one");
    end
  end
  ////////////////////////////////////////////////////////////////
  logic [7:0] mode_r;
  logic [7:0] map2_r;
  logic [7:0] test_r;
  logic [15:0] rate_r;
  logic [13:0] dev_r;
  logic [15:0] stage_r;
  logic [23:0] freq_r;
  logic [15:0] osc_cnt_r;
  logic osc_ok_r;
  logic coarse_done_r;
  logic [15:0] seq_cnt_r;
  sbm_pkg::sbm_seq_t seq_r;
  sbm_pkg::sbm_seq_t seq_nxt;
  logic [15:0] br_cnt_r;
  logic tx_bit_clock_r;
  logic [7:0] ck_cnt_r;
  logic ck_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic lock_r;
  logic txen_r;
  logic rxen_r;
  logic modbit_r;
  logic paon_r;
  wire logic [2:0] op_mode = mode_r[sbm_pkg::MODE_OP_LSB +: 3];
  wire logic seq_off = mode_r[sbm_pkg::MODE_SEQ_OFF_BIT];
  wire logic shaped = mode_r[sbm_pkg::MODE_SHAPE_BIT];
  wire logic ook = mode_r[sbm_pkg::MODE_OOK_BIT];
  wire logic [2:0] ck_sel = map2_r[2:0];
  wire logic wr_lo = lnk.reg_we && lnk.reg_addr == sbm_pkg::REG_FREQ_LO;
  wire logic pll_want = op_mode == sbm_pkg::OP_FS || op_mode == sbm_pkg::OP_TX
    || op_mode == sbm_pkg::OP_RX;
  wire logic want_path = op_mode == sbm_pkg::OP_TX || op_mode == sbm_pkg::OP_RX;
  // a divider below four would leave the host no whole cycle between rise and fall
  wire logic [15:0] br_div = (rate_r < 16'h0004) ? 16'h0004 : rate_r;
  wire logic [15:0] br_half = {1'b0, br_div[15:1]};
  wire logic run_clk = txen_r && shaped;
  wire logic tx_bit_clock_fall = tx_bit_clock_r && br_cnt_r >= br_half - 16'h0001;
  wire logic [7:0] ck_half = 8'h01 << ck_sel;
  wire logic dev_tick = br_cnt_r >= br_div - 16'h0001;
  wire logic [7:0] status = {3'h0, cal_busy, txen_r, rxen_r, lock_r, osc_ok_r};
  // fsk picks data bit, ook gates amplifier
  wire logic data_in = shaped ? lnk.tx_data : lnk.tx_data;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= sbm_pkg::MODE_RST;
      map2_r <= sbm_pkg::PIN_MAP2_RST;
      test_r <= 8'h00;
      rate_r <= sbm_pkg::RATE_RST;
      dev_r <= sbm_pkg::DEV_RST;
      stage_r <= sbm_pkg::FREQ_RST[23:8];
      freq_r <= sbm_pkg::FREQ_RST;
    end
    else if (lnk.reg_we)
    begin
      case (lnk.reg_addr)
        sbm_pkg::REG_MODE: mode_r <= lnk.reg_wdata;
        sbm_pkg::REG_RATE_HI: rate_r[15:8] <= lnk.reg_wdata;
        sbm_pkg::REG_RATE_LO: rate_r[7:0] <= lnk.reg_wdata;
        sbm_pkg::REG_DEV_HI: dev_r[13:8] <= lnk.reg_wdata[5:0];
        sbm_pkg::REG_DEV_LO: dev_r[7:0] <= lnk.reg_wdata;
        sbm_pkg::REG_FREQ_HI: stage_r[15:8] <= lnk.reg_wdata;
        sbm_pkg::REG_FREQ_MID: stage_r[7:0] <= lnk.reg_wdata;
        sbm_pkg::REG_FREQ_LO: freq_r <= {stage_r, lnk.reg_wdata};
        sbm_pkg::REG_PIN_MAP2: map2_r <= lnk.reg_wdata;
        sbm_pkg::REG_TEST_OSC: test_r <= lnk.reg_wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= lnk.reg_re;
      case (lnk.reg_addr)
        sbm_pkg::REG_MODE: rdata_r <= mode_r;
        sbm_pkg::REG_RATE_HI: rdata_r <= rate_r[15:8];
        sbm_pkg::REG_RATE_LO: rdata_r <= rate_r[7:0];
        sbm_pkg::REG_DEV_HI: rdata_r <= {2'h0, dev_r[13:8]};
        sbm_pkg::REG_DEV_LO: rdata_r <= dev_r[7:0];
        sbm_pkg::REG_FREQ_HI: rdata_r <= stage_r[15:8];
        sbm_pkg::REG_FREQ_MID: rdata_r <= stage_r[7:0];
        sbm_pkg::REG_FREQ_LO: rdata_r <= freq_r[7:0];
        sbm_pkg::REG_PIN_MAP2: rdata_r <= map2_r;
        sbm_pkg::REG_STATUS: rdata_r <= status;
        sbm_pkg::REG_TEST_OSC: rdata_r <= test_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // oscillator start-up and sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_cnt_r <= 16'h0000;
      osc_ok_r <= 1'b0;
    end
    else if (!osc_ok_r)
    begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
      osc_ok_r <= osc_cnt_r >= 16'(OSC_CYC - 1);
    end
  end
  always_comb
  begin
    seq_nxt = seq_r;
    case (seq_r)
      sbm_pkg::SBM_OFF:
        if (osc_ok_r && (pll_want || !coarse_done_r)) seq_nxt = sbm_pkg::SBM_CAL;
      sbm_pkg::SBM_CAL:
        if (seq_cnt_r == 16'h0000)
          seq_nxt = pll_want ? sbm_pkg::SBM_LOCKING : sbm_pkg::SBM_OFF;
        else if (!pll_want && coarse_done_r) seq_nxt = sbm_pkg::SBM_OFF;
      sbm_pkg::SBM_LOCKING:
        if (!pll_want) seq_nxt = sbm_pkg::SBM_OFF;
        else if (lock_r) seq_nxt = sbm_pkg::SBM_LOCKED;
      sbm_pkg::SBM_LOCKED:
        if (!pll_want) seq_nxt = sbm_pkg::SBM_OFF;
        else if (want_path && !seq_off) seq_nxt = sbm_pkg::SBM_ACTIVE;
      sbm_pkg::SBM_ACTIVE:
        if (!want_path) seq_nxt = pll_want ? sbm_pkg::SBM_LOCKED : sbm_pkg::SBM_OFF;
      default: seq_nxt = sbm_pkg::SBM_OFF;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_r <= sbm_pkg::SBM_OFF;
      seq_cnt_r <= 16'(sbm_pkg::COARSE_CAL_CYC);
      coarse_done_r <= 1'b0;
      lock_r <= 1'b0;
    end
    else
    begin
      seq_r <= seq_nxt;
      if (seq_r == sbm_pkg::SBM_OFF && seq_nxt == sbm_pkg::SBM_CAL)
      begin
        // coarse run once after reset, fine run every activation
        seq_cnt_r <= coarse_done_r ? 16'(sbm_pkg::FINE_CAL_CYC) :
          16'(sbm_pkg::COARSE_CAL_CYC + sbm_pkg::FINE_CAL_CYC);
      end
      else if (seq_r == sbm_pkg::SBM_CAL || seq_r == sbm_pkg::SBM_LOCKING)
        seq_cnt_r <= (seq_cnt_r == 16'h0000) ? 16'h0000 : seq_cnt_r - 16'h0001;
      if (seq_r == sbm_pkg::SBM_CAL && seq_nxt == sbm_pkg::SBM_LOCKING)
        seq_cnt_r <= 16'(LOCK_WAIT - 1);
      // the coarse run after reset is never cut short
      if (seq_r == sbm_pkg::SBM_CAL && seq_cnt_r == 16'h0000)
        coarse_done_r <= 1'b1;
      lock_r <= (seq_r == sbm_pkg::SBM_LOCKING && seq_cnt_r == 16'h0000 && pll_in_range)
        || ((seq_r == sbm_pkg::SBM_LOCKED || seq_r == sbm_pkg::SBM_ACTIVE) && pll_in_range);
    end
  end
  ////////////////////////////////////////////////////////////////
  // bit clock, clock out, modulator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      br_cnt_r <= 16'h0000;
      tx_bit_clock_r <= 1'b0;
      ck_cnt_r <= 8'h00;
      ck_r <= 1'b0;
      modbit_r <= 1'b0;
      paon_r <= 1'b0;
      txen_r <= 1'b0;
      rxen_r <= 1'b0;
    end
    else
    begin
      txen_r <= seq_r == sbm_pkg::SBM_ACTIVE && op_mode == sbm_pkg::OP_TX
        || seq_off && lock_r && op_mode == sbm_pkg::OP_TX;
      rxen_r <= seq_r == sbm_pkg::SBM_ACTIVE && op_mode == sbm_pkg::OP_RX
        || seq_off && lock_r && op_mode == sbm_pkg::OP_RX;
      // one bit per divider cycles; a started high phase always ends whole
      br_cnt_r <= (dev_tick || !(run_clk || tx_bit_clock_r)) ? 16'h0000 : br_cnt_r + 16'h0001;
      if (run_clk && dev_tick)
        tx_bit_clock_r <= 1'b1;
      else if (tx_bit_clock_fall)
        tx_bit_clock_r <= 1'b0;
      if (run_clk && tx_bit_clock_fall)
        modbit_r <= data_in;
      if (txen_r && !shaped)
        modbit_r <= data_in;
      paon_r <= txen_r && (!ook || data_in);
      if (!osc_ok_r || op_mode == sbm_pkg::OP_SLEEP || ck_sel == sbm_pkg::REFERENCE_CLOCK_OUT_OFF)
      begin
        ck_cnt_r <= 8'h00;
        ck_r <= 1'b0;
      end
      else if (ck_cnt_r >= ck_half - 8'h01)
      begin
        ck_cnt_r <= 8'h00;
        ck_r <= ~ck_r;
      end
      else
        ck_cnt_r <= ck_cnt_r + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  assign lnk.reg_rdata = rdata_r;
  assign lnk.reg_rvalid = rvalid_r;
  assign lnk.tx_bit_clock = tx_bit_clock_r;
  assign lnk.reference_clock_out = ck_r;
  assign lnk.lock_ind = lock_r;
  assign lnk.ext_clk_req = test_r[sbm_pkg::EXT_CLK_BIT];
  // output frequency is step times the committed word
  assign synth_word = freq_r;
  assign dev_word = dev_r;
  assign mod_bit = modbit_r;
  assign pa_on = paon_r;
  assign rx_en = rxen_r;
  assign cal_busy = seq_r == sbm_pkg::SBM_CAL;
endmodule

/* sbm_host.sv */
`timescale 1ns/10ps
module sbm_host (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  sbm_link_if.host lnk // device link
);
  ////////////////////////////////////////////////////////////////
  logic [6:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic busy_r;
  logic we_r;
  logic re_r;
  logic [31:0] txbits_r;
  logic [5:0] txcnt_r;
  logic txd_r;
  logic tx_bit_clock_q_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  wire logic acc = psel && penable && !pready_r;
  wire logic wr = acc && pwrite;
  wire logic hit = paddr == sbm_pkg::CTL_ADDR || paddr == sbm_pkg::CTL_WDATA
    || paddr == sbm_pkg::CTL_CMD || paddr == sbm_pkg::CTL_STAT
    || paddr == sbm_pkg::CTL_TXBITS;
  wire logic tx_bit_clock_rise = lnk.tx_bit_clock && !tx_bit_clock_q_r;
  wire logic [31:0] stat = {26'h0, lnk.ext_clk_req, lnk.reference_clock_out,
    lnk.lock_ind, txcnt_r == 6'h00, 1'b0, busy_r};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_r <= 7'h00;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      busy_r <= 1'b0;
      we_r <= 1'b0;
      re_r <= 1'b0;
      txbits_r <= 32'h0;
      txcnt_r <= 6'h00;
      txd_r <= 1'b0;
      tx_bit_clock_q_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= acc;
      pslverr_r <= acc && !hit;
      prdata_r <= 32'h0;
      we_r <= 1'b0;
      re_r <= 1'b0;
      tx_bit_clock_q_r <= lnk.tx_bit_clock;
      if (lnk.reg_rvalid)
      begin
        rdata_r <= lnk.reg_rdata;
        busy_r <= 1'b0;
      end
      if (acc && !pwrite)
      begin
        case (paddr)
          sbm_pkg::CTL_ADDR: prdata_r <= {25'h0, addr_r};
          sbm_pkg::CTL_WDATA: prdata_r <= {24'h0, rdata_r};
          sbm_pkg::CTL_STAT: prdata_r <= stat;
          sbm_pkg::CTL_TXBITS: prdata_r <= txbits_r;
          default: prdata_r <= 32'h0;
        endcase
      end
      if (wr && paddr == sbm_pkg::CTL_ADDR)
        addr_r <= pwdata[6:0];
      if (wr && paddr == sbm_pkg::CTL_WDATA)
        wdata_r <= pwdata[7:0];
      if (wr && paddr == sbm_pkg::CTL_CMD && !busy_r)
      begin
        we_r <= pwdata[0];
        re_r <= pwdata[1];
        busy_r <= pwdata[1];
      end
      // cmd bit2 sets the data pin to bit3 for unclocked transmission
      if (wr && paddr == sbm_pkg::CTL_CMD && pwdata[2])
        txd_r <= pwdata[3];
      if (wr && paddr == sbm_pkg::CTL_TXBITS)
      begin
        txbits_r <= pwdata;
        txcnt_r <= 6'h20;
      end
      else if (tx_bit_clock_rise && txcnt_r != 6'h00)
      begin
        // change data after rising edge; device samples on the falling one
        txd_r <= txbits_r[0];
        txbits_r <= {1'b0, txbits_r[31:1]};
        txcnt_r <= txcnt_r - 6'h01;
      end
    end
  end
  assign lnk.reg_we = we_r;
  assign lnk.reg_re = re_r;
  assign lnk.reg_addr = addr_r;
  assign lnk.reg_wdata = wdata_r;
  assign lnk.tx_data = txd_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule

/* sbm_monitor.sv */
`timescale 1ns/10ps
module sbm_monitor #(
  parameter int OSC_CYC = 64
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic reg_we, // write strobe
  input wire logic reg_re, // read strobe
  input wire logic [6:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write byte
  input wire logic [7:0] reg_rdata, // read byte
  input wire logic reg_rvalid, // read answer
  input wire logic tx_data, // transmit bit
  input wire logic tx_bit_clock, // bit clock
  input wire logic reference_clock_out, // clock out pin
  input wire logic lock_ind, // lock flag
  input wire logic ext_clk_req // external clock select
);
  localparam int CLK_WIN = 32;
  int osc_cnt_r;
  logic [15:0] rate_r;
  logic [15:0] hi_cnt_r;
  wire ext_wr = reg_we && reg_addr == sbm_pkg::REG_TEST_OSC;
  wire rate_hi_wr = reg_we && reg_addr == sbm_pkg::REG_RATE_HI;
  wire rate_lo_wr = reg_we && reg_addr == sbm_pkg::REG_RATE_LO;
  wire osc_run = osc_cnt_r < OSC_CYC + 3;
  // high phase is half of one bit period of divider cycles, two at the least
  wire [15:0] half_exp = (rate_r < 16'h0004) ? 16'h0002 : {1'b0, rate_r[15:1]};
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the bit-rate divider and a saturating start-up counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_cnt_r <= 0;
      rate_r <= sbm_pkg::RATE_RST;
      hi_cnt_r <= 16'h0000;
    end
    else
    begin
      osc_cnt_r <= osc_run ? osc_cnt_r + 1 : osc_cnt_r;
      if (rate_hi_wr)
        rate_r[15:8] <= reg_wdata;
      if (rate_lo_wr)
        rate_r[7:0] <= reg_wdata;
      hi_cnt_r <= tx_bit_clock ? hi_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_req;
    reg_re;
  endsequence
  sequence s_ans;
    ##1 reg_rvalid;
  endsequence
  chk_read_answer: assert property (s_req |-> s_ans)
    else $error("read answer missing");
  chk_answer_cause: assert property (reg_rvalid |-> $past(reg_re))
    else $error("read answer without request");
  chk_ext_select: assert property (ext_wr |=> ext_clk_req == $past(reg_wdata[4]))
    else $error("external clock select wrong");
  chk_ext_hold: assert property (!ext_wr |=> $stable(ext_clk_req))
    else $error("external clock select moved");
  chk_reference_clock_out_wait: assert property (osc_cnt_r < OSC_CYC - 1 |-> !reference_clock_out)
    else $error("clock out before crystal stable");
  chk_reference_clock_out_default: assert property (osc_cnt_r == OSC_CYC + 2 |-> ##[0:CLK_WIN] $changed(reference_clock_out))
    else $error("clock out not running");
  chk_data_held: assert property ($fell(tx_bit_clock) |-> $stable(tx_data))
    else $error("data moved at bit clock fall");
  chk_bit_half: assert property ($fell(tx_bit_clock) |-> hi_cnt_r == half_exp)
    else $error("bit clock high phase wrong");
  chk_strobe_excl: assert property (!(reg_we && reg_re))
    else $error("write and read together");
endmodule

/* tb_synth_rate_divider_field_modulation_ctrl.sv */
`timescale 1ns/10ps
module tb_synth_rate_divider_field_modulation_ctrl;
  localparam int OSC = 64;
  logic pclk, presetn, psel, penable, pwrite, pll_in_range, err, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] synth_word;
  logic [13:0] dev_word;
  logic mod_bit, pa_on, rx_en, cal_busy, p;
  logic [7:0] b, bits;
  int fail_count, tests_run, cal_cnt, t, n, i;
  sbm_link_if lnk();
  sbm_device #(.OSC_CYC(OSC), .LOCK_WAIT(32)) i_sbm_device (.pclk(pclk), .presetn(presetn),
    .lnk(lnk.dev), .pll_in_range(pll_in_range), .synth_word(synth_word), .dev_word(dev_word),
    .mod_bit(mod_bit), .pa_on(pa_on), .rx_en(rx_en), .cal_busy(cal_busy));
  sbm_host i_sbm_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk.host));
  sbm_monitor #(.OSC_CYC(OSC)) i_sbm_monitor (.pclk(pclk), .presetn(presetn),
    .reg_we(lnk.reg_we), .reg_re(lnk.reg_re), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid),
    .tx_data(lnk.tx_data), .tx_bit_clock(lnk.tx_bit_clock),
    .reference_clock_out(lnk.reference_clock_out), .lock_ind(lnk.lock_ind),
    .ext_clk_req(lnk.ext_clk_req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dev_go(input logic [6:0] idx, input logic [31:0] cmd);
    int k;
    apb(1'b1, sbm_pkg::CTL_ADDR, {25'h0000000, idx});
    apb(1'b1, sbm_pkg::CTL_CMD, cmd);
    k = 0;
    do apb(1'b0, sbm_pkg::CTL_STAT, 32'h00000000); while (q[0] !== 1'b0 && ++k < 50);
    if (q[0] !== 1'b0)
      fail_count++;
  endtask
  task automatic dev_wr(input logic [6:0] idx, input logic [7:0] d);
    apb(1'b1, sbm_pkg::CTL_WDATA, {24'h000000, d});
    dev_go(idx, 32'h00000001);
  endtask
  task automatic dev_rd(input logic [6:0] idx);
    dev_go(idx, 32'h00000002);
    apb(1'b0, sbm_pkg::CTL_WDATA, 32'h00000000);
    b = q[7:0];
  endtask
  task automatic tog(input int cyc);
    t = 0;
    p = lnk.reference_clock_out;
    repeat (cyc)
    begin
      @(posedge pclk);
      if (lnk.reference_clock_out !== p)
        t++;
      p = lnk.reference_clock_out;
    end
  endtask
  task automatic wait_on(input int w);
    n = 0;
    while (((w == 0) ? pa_on : rx_en) !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge cal_busy) cal_cnt++;
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    test_done();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, pll_in_range} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    tog(20);
    chk("reference_clock_out_early", t, 0);
    chk("freq_reset", synth_word, sbm_pkg::FREQ_RST);
    chk("dev_reset", dev_word, sbm_pkg::DEV_RST);
    dev_rd(sbm_pkg::REG_RATE_HI);
    chk("rate_hi", b, sbm_pkg::RATE_RST[15:8]);
    dev_rd(sbm_pkg::REG_RATE_LO);
    chk("rate_lo", b, sbm_pkg::RATE_RST[7:0]);
    repeat (OSC) @(posedge pclk);
    chk("coarse_cal", cal_cnt, 1);
    tog(32);
    chk("reference_clock_out_default", t, 32);
    dev_wr(sbm_pkg::REG_PIN_MAP2, 8'h02);
    tog(32);
    chk("reference_clock_out_div", t, 8);
    dev_wr(sbm_pkg::REG_PIN_MAP2, {5'h00, sbm_pkg::REFERENCE_CLOCK_OUT_OFF});
    tog(16);
    chk("reference_clock_out_off", t, 0);
    dev_wr(sbm_pkg::REG_PIN_MAP2, 8'h00);
    dev_wr(sbm_pkg::REG_MODE, {5'h00, sbm_pkg::OP_SLEEP});
    tog(16);
    chk("reference_clock_out_sleep", t, 0);
    dev_wr(sbm_pkg::REG_MODE, sbm_pkg::MODE_RST);
    $display("test reset and clock out done");
    dev_wr(sbm_pkg::REG_FREQ_HI, 8'h12);
    dev_wr(sbm_pkg::REG_FREQ_MID, 8'h34);
    chk("freq_staged", synth_word, sbm_pkg::FREQ_RST);
    dev_wr(sbm_pkg::REG_FREQ_LO, 8'h56);
    chk("freq_commit", synth_word, 24'h123456);
    dev_rd(sbm_pkg::REG_FREQ_MID);
    chk("freq_mid", b, 8'h34);
    // deviation chosen above the minimum and inside the rate limit
    dev_wr(sbm_pkg::REG_DEV_HI, 8'h01);
    dev_wr(sbm_pkg::REG_DEV_LO, 8'h48);
    chk("dev_word", dev_word, 14'h0148);
    dev_wr(sbm_pkg::REG_TEST_OSC, 8'h10);
    chk("ext_on", lnk.ext_clk_req, 1);
    apb(1'b0, sbm_pkg::CTL_STAT, 32'h00000000);
    chk("ext_status", q[5], 1);
    dev_wr(sbm_pkg::REG_TEST_OSC, 8'h00);
    chk("ext_off", lnk.ext_clk_req, 0);
    apb(1'b0, 12'h040, 32'h00000000);
    chk("unmapped", err, 1);
    $display("test registers done");
    i = cal_cnt;
    dev_wr(sbm_pkg::REG_MODE, {5'h00, sbm_pkg::OP_TX});
    repeat (60) @(posedge pclk);
    chk("no_lock", lnk.lock_ind, 0);
    chk("tx_wait", pa_on, 0);
    chk("fine_cal", cal_cnt, i + 1);
    pll_in_range <= 1'b1;
    wait_on(0);
    chk("lock", lnk.lock_ind, 1);
    chk("tx_on", pa_on, 1);
    pll_in_range <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("unlock", lnk.lock_ind, 0);
    dev_wr(sbm_pkg::REG_MODE, sbm_pkg::MODE_RST);
    pll_in_range <= 1'b1;
    dev_wr(sbm_pkg::REG_MODE, {5'h00, sbm_pkg::OP_RX});
    wait_on(1);
    chk("rx_on", rx_en, 1);
    $display("test sequencer done");
    dev_wr(sbm_pkg::REG_MODE, sbm_pkg::MODE_RST);
    dev_wr(sbm_pkg::REG_RATE_HI, 8'h00);
    dev_wr(sbm_pkg::REG_RATE_LO, 8'h04);
    apb(1'b1, sbm_pkg::CTL_TXBITS, 32'h000000b5);
    dev_wr(sbm_pkg::REG_MODE, 8'h13);
    i = 0;
    p = 1'b0;
    repeat (300)
    begin
      @(posedge pclk);
      if (p === 1'b1 && lnk.tx_bit_clock === 1'b0 && i < 8)
        bits[i++] = lnk.tx_data;
      p = lnk.tx_bit_clock;
    end
    chk("shaped_bits", bits, 8'hb5);
    dev_wr(sbm_pkg::REG_MODE, {5'h00, sbm_pkg::OP_TX});
    apb(1'b1, sbm_pkg::CTL_CMD, 32'h0000000c);
    @(posedge pclk);
    chk("plain_one", mod_bit, 1);
    apb(1'b1, sbm_pkg::CTL_CMD, 32'h00000004);
    @(posedge pclk);
    chk("plain_zero", mod_bit, 0);
    repeat (8)
    begin
      p = lnk.tx_data;
      @(posedge pclk);
      chk("plain_bit", mod_bit, p);
    end
    dev_wr(sbm_pkg::REG_MODE, 8'h23);
    repeat (2) @(posedge pclk);
    chk("ook_space", pa_on, 0);
    apb(1'b1, sbm_pkg::CTL_CMD, 32'h0000000c);
    repeat (2) @(posedge pclk);
    chk("ook_mark", pa_on, 1);
    dev_wr(sbm_pkg::REG_MODE, sbm_pkg::MODE_RST);
    dev_wr(sbm_pkg::REG_MODE, 8'h0b);
    chk("manual_wait", pa_on, 0);
    n = 0;
    do apb(1'b0, sbm_pkg::CTL_STAT, 32'h00000000); while (q[3] !== 1'b1 && ++n < 100);
    chk("manual_lock", q[3], 1);
    repeat (2) @(posedge pclk);
    chk("manual_tx", pa_on, 1);
    $display("test transmit data done");
    test_done();
  end
endmodule
